// [hw/spf_framer.sv]
// Operation
// - Multi-byte fields sent little-endian, unsigned unless signed
// - Point body starts with two-byte azimuth
// - Sixteen three-byte records, channel one first
// - Record is range word then reflectivity byte
// - Reflectivity byte maps linearly to percent
// - Motion body starts with signed X Y Z acceleration
// - Then signed X Y Z angular velocity
// - Motion body ends with sixteen-bit sequence number
// - Four-byte CRC over pre-header through body
// - Motion CRC input padded with two zeros
// - Fault message emitted once every second
// - Fault starts EE DD, revision, date, timestamp
// - Date bytes year-1900, month, day, hour, minute, second
// - Date whole seconds, sub-second carried separately
// - Timestamp holds microseconds zero to 999999
// - State byte top bits state, bits 4:3 reserved
// - Low three bits roll counter per update
// - Next byte high nibble counts queued faults
// - Low nibble gives queue position from one
// - Then fault code and twenty reserved bytes
// - Fault CRC covers state byte through reserved
//
// Implementation choices: the register addresses and the plain strobed port.
`default_nettype none
module spf_framer #(
	parameter int unsigned FLT_PERIOD = spf_pkg::FLT_PERIOD_CYC
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o,
	// Point cloud request
	input wire logic pc_start_i,
	input wire logic [31:0] crc_seed_i,
	input wire logic [15:0] azimuth_i,
	input wire spf_pkg::spf_rec_t [15:0] rec_i,
	// Motion request
	input wire logic imu_start_i,
	input wire spf_pkg::spf_imu_t imu_i,
	// Fault message sources
	input wire logic [2:0] sensor_state_i,
	input wire logic [3:0] fault_count_i,
	input wire logic [14:0][15:0] fault_code_i,
	input wire spf_pkg::spf_date_t date_i,
	input wire logic [19:0] usec_i,
	// Byte stream toward the serializer
	output logic [7:0] byte_o,
	output logic byte_valid_o,
	output logic byte_last_o,
	input wire logic byte_ready_i,
	output logic busy_o
);

	typedef enum logic [1:0] {ST_IDLE, ST_BODY, ST_PAD, ST_TAIL} spf_state_t;

	// Sequencer state
	spf_state_t state_r, state_nxt;
	spf_pkg::spf_kind_t kind_r, kind_nxt;
	logic [5:0] idx_r, idx_nxt; // Byte index inside the current section
	logic [31:0] crc_r, crc_nxt; // Running checksum
	// Output holding register
	logic vld_r, vld_nxt;
	logic [7:0] dat_r, dat_nxt;
	logic last_r, last_nxt;
	logic busy_r;
	// Latched packet content, frozen for the whole packet
	logic [15:0] az_r;
	spf_pkg::spf_rec_t [15:0] rec_r;
	spf_pkg::spf_imu_t imu_r;
	logic [15:0] imu_seq_r; // Sequence carried by the packet in flight
	logic [15:0] seq_r; // Next motion sequence number
	logic [7:0] flt_state_r;
	logic [7:0] flt_pos_byte_r;
	logic [15:0] flt_code_r;
	spf_pkg::spf_date_t date_r;
	logic [19:0] usec_r;
	logic [7:0] rev_r;
	logic [7:0] rev_nxt_r; // Revision for the next fault message, set by software
	// Fault scheduling
	logic [31:0] tmr_r;
	logic flt_pend_r;
	logic [2:0] roll_r;
	logic [3:0] pos_r;
	// Registers
	logic flt_en_r;
	logic [31:0] rdata_r;

	// Byte images of the three bodies
	logic [7:0] pc_b [50];
	logic [7:0] imu_b [14];
	logic [7:0] flt_b [37];
	logic [15:0] imu_w [7];

	// Handshake and start decode
	wire slot = !vld_r || byte_ready_i; // Output register can take a byte
	wire acc = vld_r && byte_ready_i; // Byte accepted downstream
	// Waiting for the last byte to drain keeps kind stable while it is still visible
	wire start_ok = (state_r == ST_IDLE) && !vld_r;
	wire take_flt = start_ok && flt_pend_r && flt_en_r;
	wire take_pc = start_ok && !take_flt && pc_start_i;
	wire take_imu = start_ok && !take_flt && !pc_start_i && imu_start_i;
	wire take_any = take_flt || take_pc || take_imu;
	wire tick = (tmr_r == FLT_PERIOD - 1);

	// Queue position steps 1..count and wraps; empty queue reports zero
	wire [3:0] pos_nxt = (fault_count_i == 4'h0) ? 4'h0 :
		((pos_r >= fault_count_i) ? 4'h1 : pos_r + 4'h1);
	wire [3:0] code_sel = pos_nxt - 4'h1;
	wire [15:0] code_nxt = (pos_nxt == 4'h0) ? 16'h0000 : fault_code_i[code_sel];

	// Point cloud body: azimuth then sixteen records
	assign pc_b[0] = az_r[7:0];
	assign pc_b[1] = az_r[15:8];
	for (genvar ch = 0; ch < spf_pkg::NUM_CH; ch++) begin : g_rec
		assign pc_b[2 + 3 * ch] = rec_r[ch].range[7:0];
		assign pc_b[3 + 3 * ch] = rec_r[ch].range[15:8];
		// Reflectivity passes through untouched, one count per percent
		assign pc_b[4 + 3 * ch] = rec_r[ch].refl;
	end

	// Motion body: accel, gyro, sequence, each low byte first
	assign imu_w[0] = imu_r.ax;
	assign imu_w[1] = imu_r.ay;
	assign imu_w[2] = imu_r.az;
	assign imu_w[3] = imu_r.gx;
	assign imu_w[4] = imu_r.gy;
	assign imu_w[5] = imu_r.gz;
	assign imu_w[6] = imu_seq_r;
	for (genvar w = 0; w < 7; w++) begin : g_imu
		assign imu_b[2 * w] = imu_w[w][7:0];
		assign imu_b[2 * w + 1] = imu_w[w][15:8];
	end

	// Fault body
	assign flt_b[0] = spf_pkg::FLT_SOP0;
	assign flt_b[1] = spf_pkg::FLT_SOP1;
	assign flt_b[2] = rev_r;
	assign flt_b[3] = date_r.year;
	assign flt_b[4] = date_r.month;
	assign flt_b[5] = date_r.day;
	assign flt_b[6] = date_r.hour;
	assign flt_b[7] = date_r.minute;
	assign flt_b[8] = date_r.second;
	assign flt_b[9] = usec_r[7:0];
	assign flt_b[10] = usec_r[15:8];
	assign flt_b[11] = {4'h0, usec_r[19:16]};
	assign flt_b[12] = 8'h00;
	assign flt_b[13] = flt_state_r;
	assign flt_b[14] = flt_pos_byte_r;
	assign flt_b[15] = flt_code_r[7:0];
	assign flt_b[16] = flt_code_r[15:8];
	for (genvar r = 0; r < spf_pkg::FLT_RSVD_LEN; r++) begin : g_rsvd
		assign flt_b[17 + r] = 8'h00;
	end

	// Body byte and checksum window for the current packet kind
	wire [7:0] body_b = (kind_r == spf_pkg::KIND_PC) ? pc_b[idx_r] :
		(kind_r == spf_pkg::KIND_IMU) ? imu_b[idx_r[3:0]] : flt_b[idx_r];
	wire [5:0] body_len = (kind_r == spf_pkg::KIND_PC) ? spf_pkg::PC_BODY_LEN :
		(kind_r == spf_pkg::KIND_IMU) ? spf_pkg::IMU_BODY_LEN : spf_pkg::FLT_BODY_LEN;
	// Fault checksum skips the start bytes, revision and time fields
	wire crc_on = (kind_r != spf_pkg::KIND_FLT) || (idx_r >= spf_pkg::FLT_CRC_FIRST);
	wire [7:0] tail_b = crc_r[{idx_r[1:0], 3'b000} +: 8];

	// Sequencer: body, optional zero padding into the checksum, tail
	always_comb begin
		state_nxt = state_r;
		kind_nxt = kind_r;
		idx_nxt = idx_r;
		crc_nxt = crc_r;
		vld_nxt = vld_r && !byte_ready_i;
		dat_nxt = dat_r;
		last_nxt = last_r;
		case (state_r)
			ST_IDLE: begin
				if (take_any) begin
					state_nxt = ST_BODY;
					idx_nxt = 6'd0;
					kind_nxt = take_flt ? spf_pkg::KIND_FLT :
						(take_pc ? spf_pkg::KIND_PC : spf_pkg::KIND_IMU);
					// Upstream hands over the checksum of its pre-header and header
					crc_nxt = take_flt ? spf_pkg::CRC_INIT : crc_seed_i;
				end
			end
			ST_BODY: begin
				if (slot) begin
					vld_nxt = 1'b1;
					dat_nxt = body_b;
					last_nxt = 1'b0;
					if (crc_on) begin
						crc_nxt = spf_pkg::crc_byte(crc_r, body_b);
					end
					idx_nxt = idx_r + 6'd1;
					if (idx_r == body_len - 6'd1) begin
						idx_nxt = 6'd0;
						state_nxt = (kind_r == spf_pkg::KIND_IMU) ? ST_PAD : ST_TAIL;
					end
				end
			end
			ST_PAD: begin
				// Zero bytes go through the checksum only, never onto the wire
				crc_nxt = spf_pkg::crc_byte(crc_r, 8'h00);
				idx_nxt = idx_r + 6'd1;
				if (idx_r == spf_pkg::IMU_PAD_LEN - 6'd1) begin
					idx_nxt = 6'd0;
					state_nxt = ST_TAIL;
				end
			end
			ST_TAIL: begin
				if (slot) begin
					vld_nxt = 1'b1;
					dat_nxt = tail_b;
					last_nxt = (idx_r == spf_pkg::CRC_LEN - 6'd1);
					idx_nxt = idx_r + 6'd1;
					if (idx_r == spf_pkg::CRC_LEN - 6'd1) begin
						idx_nxt = 6'd0;
						state_nxt = ST_IDLE;
					end
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Sequencer and output registers
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state_r <= ST_IDLE;
			kind_r <= spf_pkg::KIND_PC;
			idx_r <= 6'd0;
			crc_r <= spf_pkg::CRC_INIT;
			vld_r <= 1'b0;
			dat_r <= 8'h00;
			last_r <= 1'b0;
			busy_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			kind_r <= kind_nxt;
			idx_r <= idx_nxt;
			crc_r <= crc_nxt;
			vld_r <= vld_nxt;
			dat_r <= dat_nxt;
			last_r <= last_nxt;
			busy_r <= (state_nxt != ST_IDLE) || vld_nxt;
		end
	end

	// Content capture; inputs may change freely once a packet is taken
	always_ff @(posedge clk_sys_i) begin
		if (take_pc) begin
			az_r <= azimuth_i;
			rec_r <= rec_i;
		end
		if (take_imu) begin
			imu_r <= imu_i;
			imu_seq_r <= seq_r;
		end
		if (take_flt) begin
			flt_state_r <= {sensor_state_i, 2'b00, roll_r};
			flt_pos_byte_r <= {fault_count_i, pos_nxt};
			flt_code_r <= code_nxt;
			date_r <= date_i;
			usec_r <= usec_i;
			rev_r <= rev_nxt_r;
		end
	end

	// Counters that live across packets
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			seq_r <= 16'h0000;
			roll_r <= 3'h0;
			pos_r <= 4'h0;
			tmr_r <= 32'h0;
			flt_pend_r <= 1'b0;
		end else begin
			if (take_imu) begin
				seq_r <= seq_r + 16'h0001;
			end
			if (take_flt) begin
				roll_r <= roll_r + 3'h1;
				pos_r <= pos_nxt;
			end
			tmr_r <= tick ? 32'h0 : tmr_r + 32'h1;
			// A new period tick wins over the take that clears the flag
			flt_pend_r <= (tick && flt_en_r) || (flt_pend_r && !take_flt);
		end
	end

	// Register port: control write, control and status read one cycle later
	wire wr_ctrl = reg_we_i && (reg_addr_i == spf_pkg::REG_CTRL);
	wire [31:0] ctrl_rd = {16'h0000, rev_nxt_r, 7'h00, flt_en_r};
	wire [31:0] stat_rd = {seq_r, 4'h0, pos_r, 1'b0, roll_r, 3'h0, busy_r};
	wire [31:0] rd_mux = (reg_addr_i == spf_pkg::REG_CTRL) ? ctrl_rd :
		(reg_addr_i == spf_pkg::REG_STATUS) ? stat_rd : 32'h0;
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			flt_en_r <= spf_pkg::CTRL_FLT_EN_RST;
			rev_nxt_r <= spf_pkg::CTRL_REV_RST;
			rdata_r <= 32'h0;
		end else begin
			if (wr_ctrl) begin
				flt_en_r <= reg_wdata_i[spf_pkg::CTRL_FLT_EN_BIT];
				rev_nxt_r <= reg_wdata_i[spf_pkg::CTRL_REV_LSB +: 8];
			end
			rdata_r <= reg_re_i ? rd_mux : 32'h0;
		end
	end

	// Outputs straight from flops
	assign byte_o = dat_r;
	assign byte_valid_o = vld_r;
	assign byte_last_o = last_r;
	assign busy_o = busy_r;
	assign reg_rdata_o = rdata_r;

	// Helper: count of accepted bytes in the packet on the wire
	logic [5:0] txc_r;
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			txc_r <= 6'd0;
		end else if (acc) begin
			txc_r <= last_r ? 6'd0 : txc_r + 6'd1;
		end
	end
	wire a_pc = acc && (kind_r == spf_pkg::KIND_PC);
	wire a_imu = acc && (kind_r == spf_pkg::KIND_IMU);
	wire a_flt = acc && (kind_r == spf_pkg::KIND_FLT);

	property p_pc_az;
		@(posedge clk_sys_i) disable iff (reset_i)
		a_pc && txc_r <= 6'd1 |-> dat_r == ((txc_r == 6'd0) ? az_r[7:0] : az_r[15:8]);
	endproperty
	a_pc_az: assert property (p_pc_az) else $error("azimuth bytes wrong");
	property p_pc_rec;
		@(posedge clk_sys_i) disable iff (reset_i)
		a_pc && txc_r == 6'd2 |-> dat_r == rec_r[0].range[7:0];
	endproperty
	a_pc_rec: assert property (p_pc_rec) else $error("first record not channel one");
	property p_pc_refl;
		@(posedge clk_sys_i) disable iff (reset_i)
		a_pc && txc_r == 6'd49 |-> dat_r == rec_r[15].refl;
	endproperty
	a_pc_refl: assert property (p_pc_refl) else $error("last reflectivity wrong");
	property p_imu_acc;
		@(posedge clk_sys_i) disable iff (reset_i)
		a_imu && txc_r == 6'd1 |-> dat_r == imu_r.ax[15:8];
	endproperty
	a_imu_acc: assert property (p_imu_acc) else $error("accel X high byte wrong");
	property p_imu_gyro;
		@(posedge clk_sys_i) disable iff (reset_i)
		a_imu && txc_r == 6'd6 |-> dat_r == imu_r.gx[7:0];
	endproperty
	a_imu_gyro: assert property (p_imu_gyro) else $error("gyro X low byte wrong");
	property p_imu_seq;
		@(posedge clk_sys_i) disable iff (reset_i)
		a_imu && txc_r == 6'd12 |-> dat_r == imu_seq_r[7:0] && seq_r == imu_seq_r + 16'h0001;
	endproperty
	a_imu_seq: assert property (p_imu_seq) else $error("motion sequence wrong");
	property p_len;
		@(posedge clk_sys_i) disable iff (reset_i)
		acc && last_r |-> txc_r == ((kind_r == spf_pkg::KIND_PC) ? spf_pkg::PC_TOTAL - 6'd1 :
			(kind_r == spf_pkg::KIND_IMU) ? spf_pkg::IMU_TOTAL - 6'd1 : spf_pkg::FLT_TOTAL - 6'd1);
	endproperty
	a_len: assert property (p_len) else $error("packet length wrong");
	property p_pad;
		@(posedge clk_sys_i) disable iff (reset_i)
		state_r == ST_BODY && kind_r == spf_pkg::KIND_IMU && idx_r == 6'd13 && slot
		|=> state_r == ST_PAD ##1 state_r == ST_PAD ##1 state_r == ST_TAIL;
	endproperty
	a_pad: assert property (p_pad) else $error("zero padding not two cycles");
	property p_tick;
		@(posedge clk_sys_i) disable iff (reset_i)
		tick && flt_en_r |=> flt_pend_r;
	endproperty
	a_tick: assert property (p_tick) else $error("period tick lost");
	property p_sop;
		@(posedge clk_sys_i) disable iff (reset_i)
		a_flt && txc_r <= 6'd1 |-> dat_r == ((txc_r == 6'd0) ? spf_pkg::FLT_SOP0 : spf_pkg::FLT_SOP1);
	endproperty
	a_sop: assert property (p_sop) else $error("fault start bytes wrong");
	property p_state;
		@(posedge clk_sys_i) disable iff (reset_i)
		a_flt && txc_r == 6'd13 |-> dat_r[4:3] == 2'b00 && dat_r[2:0] == roll_r - 3'h1;
	endproperty
	a_state: assert property (p_state) else $error("state byte wrong");
	property p_roll;
		@(posedge clk_sys_i) disable iff (reset_i)
		take_flt |=> roll_r == $past(roll_r) + 3'h1;
	endproperty
	a_roll: assert property (p_roll) else $error("roll counter did not step");
	property p_pos;
		@(posedge clk_sys_i) disable iff (reset_i)
		a_flt && txc_r == 6'd14 |-> dat_r[3:0] <= dat_r[7:4] && (dat_r[7:4] == 4'h0 || dat_r[3:0] != 4'h0);
	endproperty
	a_pos: assert property (p_pos) else $error("queue position out of range");

	c_pc_done: cover property (@(posedge clk_sys_i) a_pc && last_r);
	c_imu_done: cover property (@(posedge clk_sys_i) a_imu && last_r);
	c_flt_done: cover property (@(posedge clk_sys_i) a_flt && last_r);
	c_stall: cover property (@(posedge clk_sys_i) vld_r && !byte_ready_i ##1 acc);

endmodule
`default_nettype wire

// [hw/spf_pkg.sv]
`default_nettype none
package spf_pkg;
	// Register offsets on the plain register port (byte addresses)
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	// Control register fields and reset values
	localparam int CTRL_FLT_EN_BIT = 0;
	localparam int CTRL_REV_LSB = 8;
	localparam logic CTRL_FLT_EN_RST = 1'b1;
	localparam logic [7:0] CTRL_REV_RST = 8'h01;
	// Status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ROLL_LSB = 4;
	localparam int STAT_POS_LSB = 8;
	localparam int STAT_SEQ_LSB = 16;
	// Packet layout: body lengths, padding, tail, totals
	localparam logic [5:0] PC_BODY_LEN = 6'd50;
	localparam logic [5:0] IMU_BODY_LEN = 6'd14;
	localparam logic [5:0] IMU_PAD_LEN = 6'd2;
	localparam logic [5:0] FLT_BODY_LEN = 6'd37;
	localparam logic [5:0] FLT_CRC_FIRST = 6'd13;
	localparam logic [5:0] CRC_LEN = 6'd4;
	localparam logic [5:0] PC_TOTAL = 6'd54;
	localparam logic [5:0] IMU_TOTAL = 6'd18;
	localparam logic [5:0] FLT_TOTAL = 6'd41;
	localparam int NUM_CH = 16;
	localparam int FLT_RSVD_LEN = 20;
	localparam int FLT_QUEUE_LEN = 15;
	// Fixed start bytes of a fault message
	localparam logic [7:0] FLT_SOP0 = 8'hee;
	localparam logic [7:0] FLT_SOP1 = 8'hdd;
	// CRC-32/MPEG-2: MSB first, no reflection, no final inversion
	localparam logic [31:0] CRC_POLY = 32'h04c11db7;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	// Fault message period
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned FLT_PERIOD_MS = 1000;
	localparam int unsigned FLT_PERIOD_CYC = FLT_PERIOD_MS * (CLK_HZ / 1000);
	// Packet kinds
	typedef enum logic [1:0] {KIND_PC, KIND_IMU, KIND_FLT} spf_kind_t;
	// One channel record: range in 4 mm counts, reflectivity in 1 % counts
	typedef struct packed {
		logic [7:0] refl;
		logic [15:0] range;
	} spf_rec_t;
	// Motion sample, all signed
	typedef struct packed {
		logic signed [15:0] gz;
		logic signed [15:0] gy;
		logic signed [15:0] gx;
		logic signed [15:0] az;
		logic signed [15:0] ay;
		logic signed [15:0] ax;
	} spf_imu_t;
	// Whole-second UTC, year counted from 1900
	typedef struct packed {
		logic [7:0] second;
		logic [7:0] minute;
		logic [7:0] hour;
		logic [7:0] day;
		logic [7:0] month;
		logic [7:0] year;
	} spf_date_t;
	// One byte through the CRC, most significant bit first
	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			if (r[31] ^ d[i]) begin
				r = {r[30:0], 1'b0} ^ CRC_POLY;
			end else begin
				r = {r[30:0], 1'b0};
			end
		end
		return r;
	endfunction
endpackage
`default_nettype wire

// [testbench/spf_host_sink.sv]
`default_nettype none
// Receiving host: paces the byte stream, either always ready or stalling
module spf_host_sink (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Pacing choice: low is prompt, high stalls at random
	input wire logic slow_i,
	// Handshake toward the framer
	output logic byte_ready_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] stall_r; // Stall pattern source
	// Ready moves only just after an edge; stalls land mid-packet and mid-CRC
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			stall_r <= 16'hace1;
			byte_ready_o <= 1'b0;
		end else begin
			stall_r <= {stall_r[14:0], stall_r[15] ^ stall_r[13] ^ stall_r[12] ^ stall_r[10]};
			byte_ready_o <= !slow_i || stall_r[0];
		end
	end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PER = 200; // Shortened fault period keeps the run brief
	localparam int LIMIT = 8000; // Cycle ceiling, well above the expected run
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic [3:0] reg_addr_i = 4'h0;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_we_i = 1'b0;
	logic reg_re_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic pc_start_i = 1'b0;
	logic [31:0] crc_seed_i = 32'hffffffff;
	logic [15:0] azimuth_i = 16'h0;
	spf_pkg::spf_rec_t [15:0] rec_i = '0;
	logic imu_start_i = 1'b0;
	spf_pkg::spf_imu_t imu_i = '0;
	logic [2:0] sensor_state_i = 3'h0;
	logic [3:0] fault_count_i = 4'h0;
	logic [14:0][15:0] fault_code_i = '0;
	spf_pkg::spf_date_t date_i = '0;
	logic [19:0] usec_i = 20'h0;
	logic [7:0] byte_o;
	logic byte_valid_o, byte_last_o, byte_ready_i, busy_o;
	logic slow = 1'b0; // Sink pacing
	int fail_count = 0, checks_done = 0, cyc = 0, pkts = 0, imu_seq = 0;
	logic [31:0] rng = 32'd4576; // Xorshift state
	logic [31:0] crc_acc; // Running checksum of the expected stream
	logic [8:0] expq[$]; // Expected {last, byte} in wire order
	int starts[$]; // Time in ns of each packet's first accepted byte
	logic pkt_head = 1'b1;
	logic [14:0][15:0] codes; // Fault queue contents
	// Free-running clock
	always #20 clk_sys_i = ~clk_sys_i;
	spf_framer #(.FLT_PERIOD(PER)) uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
		.pc_start_i(pc_start_i), .crc_seed_i(crc_seed_i), .azimuth_i(azimuth_i), .rec_i(rec_i),
		.imu_start_i(imu_start_i), .imu_i(imu_i), .sensor_state_i(sensor_state_i), .fault_count_i(fault_count_i),
		.fault_code_i(fault_code_i), .date_i(date_i), .usec_i(usec_i), .byte_o(byte_o),
		.byte_valid_o(byte_valid_o), .byte_last_o(byte_last_o), .byte_ready_i(byte_ready_i), .busy_o(busy_o));
	spf_host_sink host (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .slow_i(slow), .byte_ready_o(byte_ready_i));
	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction
	// Bench's own checksum step: MSB first, no reflection
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			c = (c[31] ^ d[i]) ? ({c[30:0], 1'b0} ^ 32'h04c11db7) : {c[30:0], 1'b0};
		end
		return c;
	endfunction
	task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Note one expected byte; fold it into the checksum when it is covered
	task automatic put(input logic [7:0] b, input logic fold);
		expq.push_back({1'b0, b});
		if (fold) crc_acc = crc_step(crc_acc, b);
	endtask
	task automatic put_crc();
		for (int i = 0; i < 4; i++) expq.push_back({i == 3, crc_acc[8*i +: 8]});
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_we_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_we_i <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk_sys_i);
		reg_re_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_sys_i);
		reg_re_i <= 1'b0;
		#1 chk32("reg_rdata_o", exp, reg_rdata_o);
		@(posedge clk_sys_i);
		#1 chk32("reg_rdata_o after", 32'h0, reg_rdata_o);
	endtask
	task automatic wait_pkts(input int n);
		while (pkts < n) begin
			@(posedge clk_sys_i);
			#1;
		end
		// Hand back on an edge so following stimulus lands on the clock
		@(posedge clk_sys_i);
	endtask
	task automatic wait_valid();
		do @(posedge clk_sys_i); while (byte_valid_o !== 1'b1);
	endtask
	// Point packet with boundary records at channels one and two
	task automatic prep_pc();
		spf_pkg::spf_rec_t [15:0] r;
		logic [31:0] t;
		t = rnd();
		for (int i = 0; i < 16; i++) r[i] = 24'(rnd());
		r[0] = 24'hffffff;
		r[1].refl = 8'h00;
		azimuth_i <= t[15:0];
		rec_i <= r;
		crc_seed_i <= rnd();
		crc_acc = rng;
		put(t[7:0], 1'b1);
		put(t[15:8], 1'b1);
		for (int i = 0; i < 16; i++) begin
			put(r[i].range[7:0], 1'b1);
			put(r[i].range[15:8], 1'b1);
			put(r[i].refl, 1'b1);
		end
		put_crc();
	endtask
	// Motion packet, most negative value on the first axis
	task automatic prep_imu();
		spf_pkg::spf_imu_t m;
		for (int i = 0; i < 6; i++) m[16*i +: 16] = 16'(rnd());
		m[15:0] = 16'h8000;
		imu_i <= m;
		crc_seed_i <= rnd();
		crc_acc = rng;
		for (int i = 0; i < 12; i++) put(m[8*i +: 8], 1'b1);
		put(8'(imu_seq), 1'b1);
		put(8'(imu_seq >> 8), 1'b1);
		imu_seq++;
		crc_acc = crc_step(crc_step(crc_acc, 8'h00), 8'h00);
		put_crc();
	endtask
	// Request, holding the level until the first byte shows
	task automatic send(input logic pc, input logic imu);
		@(posedge clk_sys_i);
		if (pc) prep_pc();
		else if (imu) prep_imu();
		pc_start_i <= pc;
		imu_start_i <= imu;
		wait_valid();
		chk8("busy_o", 8'h1, {7'h0, busy_o});
		pc_start_i <= 1'b0;
		// The point packet has latched its seed; only now may the motion seed replace it
		if (pc && imu) begin
			prep_imu();
			wait_pkts(pkts + 1);
			wait_valid();
		end
		imu_start_i <= 1'b0;
	endtask
	// Fault message k: state, counter and queue position step with k
	task automatic prep_flt(input int k);
		spf_pkg::spf_date_t d;
		logic [31:0] t, us;
		logic [3:0] pos;
		t = rnd();
		pos = 4'(k % 3 + 1);
		d = {8'(t[31:26] % 60), 8'(t[25:20] % 60), 8'(t[19:15] % 24), 8'(t[14:10] % 31 + 1),
			8'(t[9:6] % 12 + 1), 8'(70 + t[5:0])};
		us = (k == 0) ? 32'd999999 : rnd() % 1000000;
		date_i <= d;
		usec_i <= us[19:0];
		sensor_state_i <= 3'(k % 4);
		put(8'hee, 1'b0);
		put(8'hdd, 1'b0);
		put(8'h5a, 1'b0);
		for (int i = 0; i < 6; i++) put(d[8*i +: 8], 1'b0);
		for (int i = 0; i < 4; i++) put(us[8*i +: 8], 1'b0);
		crc_acc = 32'hffffffff;
		put({3'(k % 4), 2'b00, 3'(k % 8)}, 1'b1);
		put({4'd3, pos}, 1'b1);
		put(codes[pos - 1][7:0], 1'b1);
		put(codes[pos - 1][15:8], 1'b1);
		for (int i = 0; i < 20; i++) put(8'h00, 1'b1);
		put_crc();
	endtask
	// Monitor: every accepted byte is matched against the oldest note
	always @(posedge clk_sys_i) begin
		logic [8:0] e;
		if (!reset_i && byte_valid_o === 1'b1 && byte_ready_i === 1'b1) begin
			if (pkt_head) starts.push_back(int'($time));
			pkt_head = (byte_last_o === 1'b1);
			if (expq.size() == 0) begin
				fail_count++;
				$display("[ERR] byte_o expected none seen %h", byte_o);
			end else begin
				e = expq.pop_front();
				chk8("byte_o", e[7:0], byte_o);
				chk8("byte_last_o", {7'h0, e[8]}, {7'h0, byte_last_o});
			end
			if (byte_last_o === 1'b1) pkts++;
		end
	end
	// Hang guard
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == LIMIT) begin
			fail_count++;
			$display("[ERR] run length expected under %0d seen %0d", LIMIT, cyc);
			conclude();
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		reg_rd(spf_pkg::REG_CTRL, {16'h0, spf_pkg::CTRL_REV_RST, 7'h0, spf_pkg::CTRL_FLT_EN_RST});
		reg_wr(spf_pkg::REG_CTRL, 32'h00000100);
		reg_rd(4'h8, 32'h0);
		reg_wr(spf_pkg::REG_STATUS, rnd());
		reg_rd(spf_pkg::REG_STATUS, 32'h0);
		$display("register test done");
		// Both requests at once: point packet first, motion packet after
		slow <= 1'b1;
		send(1'b1, 1'b1);
		wait_pkts(2);
		for (int i = 0; i < 4; i++) begin
			send(i % 2 == 0, i % 2 == 1);
			wait_pkts(3 + i);
		end
		$display("stream test done");
		// Fault messages with a prompt host so their spacing is exact
		slow <= 1'b0;
		for (int i = 0; i < 15; i++) codes[i] = 16'(rnd());
		fault_code_i <= codes;
		fault_count_i <= 4'd3;
		prep_flt(0);
		reg_wr(spf_pkg::REG_CTRL, 32'h00005a01);
		for (int k = 0; k < 9; k++) begin
			wait_pkts(7 + k);
			if (k < 8) prep_flt(k + 1);
		end
		for (int k = 3; k < 9; k++) chk32("fault spacing", PER * 40, starts[6 + k] - starts[5 + k]);
		reg_wr(spf_pkg::REG_CTRL, 32'h00005a00);
		reg_rd(spf_pkg::REG_STATUS, {16'd3, 4'h0, 4'd3, 1'b0, 3'd1, 4'h0});
		reg_rd(spf_pkg::REG_CTRL, 32'h00005a00);
		chk32("queue left", 32'h0, expq.size());
		chk8("busy_o", 8'h0, {7'h0, busy_o});
		$display("fault test done");
		conclude();
	end
endmodule
`default_nettype wire
